// >>> logic/pif_flag_bank.sv
// Overview of operation
// RULE1 - Memory scanner go bit falling sets group 7 flag bit 7.
// RULE2 - Checksum busy falling sets group 7 flag bit 6.
// RULE3 - Completed nonvolatile memory operation sets group 7 flag bit 5.
// RULE4 - Oscillator accumulator rollover sets group 7 flag bit 4.
// RULE5 - Wave generators 3, 2, 1 entering shutdown set group 7 bits 2, 1, 0.
// RULE6 - Group 7 bit 3 and group 8 bits 7 and 6 always read zero.
// RULE7 - Timer 2 overflow sets group 8 bit 3, timer 1 bit 0; sticky.
// RULE8 - Period acquisition sets group 8 bit 4 (timer 2), bit 1 (timer 1).
// RULE9 - Width acquisition sets group 8 bit 5 (timer 2), bit 2 (timer 1).
// RULE10 - Flags set on events regardless of any enable bit.
// RULE11 - Software clears stale flags before setting matching enables.
// RULE12 - Flags are hardware set, software read/write, cleared by writing zero, reset zero.
// RULE13 - Interrupt requested when flag and enable set, gated by peripheral and global enables.
// RULE14 - Hardware set beats a software clear in the same cycle.
//
// Chosen here: the strobed register port and the placing of the registers.
`default_nettype none
module pif_flag_bank
	import pif_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [7:0] rd_data,
	input wire logic memscan_go_bit,
	input wire logic checksum_busy,
	input wire logic nvmem_op_done,
	input wire logic osc_rollover,
	input wire logic [2:0] wavegen_shutdown,
	input wire logic measure1_overflow,
	input wire logic measure1_period_done,
	input wire logic measure1_width_done,
	input wire logic measure2_overflow,
	input wire logic measure2_period_done,
	input wire logic measure2_width_done,
	output logic irq
);

	// Address match for one register
	function automatic logic pif_hit(input logic [3:0] a, input logic [3:0] off);
		pif_hit = (a == off);
	endfunction : pif_hit

	pif_state_t st;
	pif_state_t next_st;
	logic [7:0] set7;
	logic [7:0] set8;

	// Hardware set requests
	always_comb begin
		set7 = 8'h00;
		set8 = 8'h00;
		set7[MEMSCAN_DONE_FLAG_BIT] = st.memscan_go_prev & ~memscan_go_bit; // see RULE1
		set7[CHECKSUM_DONE_FLAG_BIT] = st.checksum_busy_prev & ~checksum_busy; // see RULE2
		set7[NVMEM_DONE_FLAG_BIT] = nvmem_op_done; // see RULE3
		set7[OSC_ROLLOVER_FLAG_BIT] = osc_rollover; // see RULE4
		for (int i = 0; i < WAVEGEN_COUNT; i++) begin
			// Entry into shutdown only
			set7[WAVEGEN1_SHUTDOWN_FLAG_BIT + i] =
				wavegen_shutdown[i] & ~st.wavegen_shutdown_prev[i]; // see RULE5
		end
		set8[MEASURE1_OVERFLOW_FLAG_BIT] = measure1_overflow; // see RULE7
		set8[MEASURE2_OVERFLOW_FLAG_BIT] = measure2_overflow; // see RULE7
		set8[MEASURE1_PERIOD_FLAG_BIT] = measure1_period_done; // see RULE8
		set8[MEASURE2_PERIOD_FLAG_BIT] = measure2_period_done; // see RULE8
		set8[MEASURE1_WIDTH_FLAG_BIT] = measure1_width_done; // see RULE9
		set8[MEASURE2_WIDTH_FLAG_BIT] = measure2_width_done; // see RULE9
	end

	// Next state
	always_comb begin
		next_st = st;
		next_st.memscan_go_prev = memscan_go_bit;
		next_st.checksum_busy_prev = checksum_busy;
		next_st.wavegen_shutdown_prev = wavegen_shutdown;
		if (wr_strobe && pif_hit(addr, GLOBAL_IRQ_CONTROL_OFF)) begin
			next_st.global_irq_enable = wr_data[GLOBAL_IRQ_ENABLE_BIT];
			next_st.peripheral_irq_enable = wr_data[PERIPHERAL_IRQ_ENABLE_BIT];
		end
		if (wr_strobe && pif_hit(addr, IRQ_ENABLE_GROUP7_OFF)) begin
			next_st.irq_enable_group7 = wr_data & GROUP7_IMPL;
		end
		if (wr_strobe && pif_hit(addr, IRQ_ENABLE_GROUP8_OFF)) begin
			next_st.irq_enable_group8 = wr_data & GROUP8_IMPL;
		end
		if (wr_strobe && pif_hit(addr, EVENT_FLAGS_GROUP7_OFF)) begin
			next_st.event_flags_group7 = wr_data; // see RULE12
		end
		if (wr_strobe && pif_hit(addr, EVENT_FLAGS_GROUP8_OFF)) begin
			next_st.event_flags_group8 = wr_data; // see RULE12
		end
		// Set wins over clear, enables play no part
		next_st.event_flags_group7 = (next_st.event_flags_group7 | set7) & GROUP7_IMPL; // see RULE14
		next_st.event_flags_group8 = (next_st.event_flags_group8 | set8) & GROUP8_IMPL; // see RULE10
		// Read data for one cycle only
		next_st.rd_data = 8'h00;
		if (rd_strobe) begin
			case (1'b1)
				pif_hit(addr, GLOBAL_IRQ_CONTROL_OFF): begin
					next_st.rd_data = {st.global_irq_enable, st.peripheral_irq_enable, 6'h00};
				end
				pif_hit(addr, IRQ_ENABLE_GROUP7_OFF): begin
					next_st.rd_data = st.irq_enable_group7;
				end
				pif_hit(addr, IRQ_ENABLE_GROUP8_OFF): begin
					next_st.rd_data = st.irq_enable_group8;
				end
				pif_hit(addr, EVENT_FLAGS_GROUP7_OFF): begin
					next_st.rd_data = st.event_flags_group7 & GROUP7_IMPL; // see RULE6
				end
				pif_hit(addr, EVENT_FLAGS_GROUP8_OFF): begin
					next_st.rd_data = st.event_flags_group8 & GROUP8_IMPL; // see RULE6
				end
				default: begin
					next_st.rd_data = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0; // see RULE12
			st.event_flags_group7 <= EVENT_FLAGS_RST;
			st.event_flags_group8 <= EVENT_FLAGS_RST;
			st.irq_enable_group7 <= IRQ_ENABLE_RST;
			st.irq_enable_group8 <= IRQ_ENABLE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data = st.rd_data;

	// Interrupt request
	assign irq = st.global_irq_enable & st.peripheral_irq_enable &
		(|(st.event_flags_group7 & st.irq_enable_group7) |
		|(st.event_flags_group8 & st.irq_enable_group8)); // see RULE13

	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	logic wr_flags7;
	logic wr_flags8;
	assign wr_flags7 = wr_strobe && pif_hit(addr, EVENT_FLAGS_GROUP7_OFF);
	assign wr_flags8 = wr_strobe && pif_hit(addr, EVENT_FLAGS_GROUP8_OFF);

	sequence s_go_fall;
		!$past(rst) && $fell(memscan_go_bit);
	endsequence

	sequence s_busy_fall;
		!$past(rst) && $fell(checksum_busy);
	endsequence

	sequence s_shut3_enter;
		!$past(rst) && $rose(wavegen_shutdown[2]);
	endsequence

	sequence s_clear_write8;
		wr_flags8 && wr_data == 8'h00 && set8 == 8'h00;
	endsequence

	AST_SCAN_SET: assert property (s_go_fall |=> st.event_flags_group7[7]) // see RULE1
		else $error("scan done flag not set");

	AST_SCAN_QUIET: assert property ( // see RULE1
		memscan_go_bit && $past(memscan_go_bit) && !wr_flags7 && !st.event_flags_group7[7]
		|=> !st.event_flags_group7[7])
		else $error("scan flag set while scan running");

	AST_CRC_SET: assert property (s_busy_fall |=> st.event_flags_group7[6]) // see RULE2
		else $error("checksum done flag not set");

	AST_NVM_SET: assert property (nvmem_op_done |=> st.event_flags_group7[5]) // see RULE3
		else $error("nvmem done flag not set");

	AST_OSC_SET: assert property (osc_rollover |=> st.event_flags_group7[4]) // see RULE4
		else $error("rollover flag not set");

	AST_SHUT_SET: assert property (s_shut3_enter |=> st.event_flags_group7[2]) // see RULE5
		else $error("wave generator 3 shutdown flag not set");

	AST_UNIMPL_ZERO: assert property ( // see RULE6
		rd_strobe && (pif_hit(addr, EVENT_FLAGS_GROUP7_OFF) || pif_hit(addr, EVENT_FLAGS_GROUP8_OFF))
		|=> ($past(addr) == EVENT_FLAGS_GROUP7_OFF) ? rd_data[3] == 1'b0 : rd_data[7:6] == 2'b00)
		else $error("unimplemented flag bit read nonzero");

	AST_UNIMPL_HELD: assert property ( // see RULE6
		st.event_flags_group7[3] == 1'b0 && st.event_flags_group8[7:6] == 2'b00)
		else $error("unimplemented flag bit stored");

	AST_OVF_STICKY: assert property ( // see RULE7
		st.event_flags_group8[3] && !wr_flags8 [*2] |=> st.event_flags_group8[3])
		else $error("overflow flag dropped without software clear");

	AST_OVF1_SET: assert property (measure1_overflow |=> st.event_flags_group8[0]) // see RULE7
		else $error("timer 1 overflow flag not set");

	AST_PERIOD_SET: assert property ( // see RULE8
		measure2_period_done ##0 !measure1_period_done
		|=> st.event_flags_group8[4] && ($past(st.event_flags_group8[1]) || wr_flags8
		|| $past(wr_flags8) || st.event_flags_group8[1] == $past(st.event_flags_group8[1])))
		else $error("timer 2 period flag not set");

	AST_WIDTH_SET: assert property ( // see RULE9
		measure1_width_done |=> st.event_flags_group8[2])
		else $error("timer 1 width flag not set");

	AST_SET_NO_ENABLE: assert property ( // see RULE10
		nvmem_op_done && !st.global_irq_enable && st.irq_enable_group7 == 8'h00
		|=> st.event_flags_group7[5] ##1 (st.event_flags_group7[5] || $past(wr_flags7)))
		else $error("flag set depends on enables");

	AST_SW_CLEAR: assert property (s_clear_write8 |=> st.event_flags_group8 == 8'h00) // see RULE12
		else $error("write of zero did not clear group 8 flags");

	AST_RESET_CLEAR: assert property ( // see RULE12
		$past(rst) |-> st.event_flags_group7 == 8'h00 && st.event_flags_group8 == 8'h00)
		else $error("flags not zero after reset");

	AST_READ_FLAGS: assert property ( // see RULE12
		rd_strobe && pif_hit(addr, EVENT_FLAGS_GROUP7_OFF)
		|=> rd_data == $past(st.event_flags_group7) ##1 (rd_data == 8'h00 || $past(rd_strobe)))
		else $error("group 7 read data wrong or held too long");

	AST_IRQ_GATED: assert property ( // see RULE13
		irq |-> st.global_irq_enable && st.peripheral_irq_enable)
		else $error("irq raised with global gates off");

	AST_IRQ_RAISE: assert property ( // see RULE13
		osc_rollover && st.global_irq_enable && st.peripheral_irq_enable
		&& st.irq_enable_group7[4] && !(wr_strobe && pif_hit(addr, GLOBAL_IRQ_CONTROL_OFF))
		&& !(wr_strobe && pif_hit(addr, IRQ_ENABLE_GROUP7_OFF)) |=> irq)
		else $error("enabled rollover did not raise irq");

	AST_SET_WINS: assert property ( // see RULE14
		wr_flags7 && wr_data == 8'h00 && nvmem_op_done |=> st.event_flags_group7[5])
		else $error("software clear beat hardware set");

	// Further event steps
	sequence s_shut1_enter;
		!$past(rst) && $rose(wavegen_shutdown[0]);
	endsequence

	sequence s_shut2_enter;
		!$past(rst) && $rose(wavegen_shutdown[1]);
	endsequence

	sequence s_quiet7;
		!$past(rst) && !wr_flags7 && !nvmem_op_done && !osc_rollover
		&& !$fell(memscan_go_bit) && !$fell(checksum_busy)
		&& (wavegen_shutdown & ~$past(wavegen_shutdown)) == 3'h0;
	endsequence

	sequence s_idle8;
		!measure1_overflow && !measure1_period_done && !measure1_width_done
		&& !measure2_overflow && !measure2_period_done && !measure2_width_done;
	endsequence

	AST_SHUT1_SET: assert property (s_shut1_enter |=> st.event_flags_group7[0]) // see RULE5
		else $error("wave generator 1 shutdown flag not set");

	AST_SHUT2_SET: assert property (s_shut2_enter |=> st.event_flags_group7[1]) // see RULE5
		else $error("wave generator 2 shutdown flag not set");

	AST_CRC_QUIET: assert property ( // see RULE2
		checksum_busy && $past(checksum_busy) && !wr_flags7 && !st.event_flags_group7[6]
		|=> !st.event_flags_group7[6])
		else $error("checksum flag set while busy");

	AST_HOLD7: assert property ( // see RULE12
		s_quiet7 |=> st.event_flags_group7 == $past(st.event_flags_group7))
		else $error("group 7 flags changed with no event or write");

	AST_HOLD8: assert property ( // see RULE7
		!wr_flags8 ##0 s_idle8 |=> $stable(st.event_flags_group8))
		else $error("group 8 flags changed with no event or write");

	AST_OVF2_SET: assert property (measure2_overflow |=> st.event_flags_group8[3]) // see RULE7
		else $error("timer 2 overflow flag not set");

	AST_PERIOD1_SET: assert property ( // see RULE8
		measure1_period_done |=> st.event_flags_group8[1])
		else $error("timer 1 period flag not set");

	AST_WIDTH2_SET: assert property ( // see RULE9
		measure2_width_done |=> st.event_flags_group8[5])
		else $error("timer 2 width flag not set");

	AST_WRITE_FLAGS8: assert property ( // see RULE12
		wr_flags8 ##0 s_idle8 |=> st.event_flags_group8 == ($past(wr_data) & GROUP8_IMPL))
		else $error("group 8 flag write not taken");

	AST_SET_WINS8: assert property ( // see RULE14
		wr_flags8 && wr_data == 8'h00 && measure2_overflow |=> st.event_flags_group8[3])
		else $error("software clear beat timer 2 overflow");

	AST_RD_IDLE_ZERO: assert property (!rd_strobe |=> rd_data == 8'h00) // see RULE12
		else $error("read data not zero outside read");

	AST_RD_FLAGS8: assert property ( // see RULE12
		rd_strobe && pif_hit(addr, EVENT_FLAGS_GROUP8_OFF)
		|=> rd_data == $past(st.event_flags_group8))
		else $error("group 8 read data wrong");

	AST_RD_UNMAPPED: assert property ( // see RULE6
		rd_strobe && addr > EVENT_FLAGS_GROUP8_OFF |=> rd_data == 8'h00)
		else $error("unmapped read not zero");

	AST_RD_CONTROL: assert property ( // see RULE13
		rd_strobe && pif_hit(addr, GLOBAL_IRQ_CONTROL_OFF) |=> rd_data[5:0] == 6'h00)
		else $error("control low bits read nonzero");

	AST_RD_ENABLE7: assert property ( // see RULE13
		rd_strobe && pif_hit(addr, IRQ_ENABLE_GROUP7_OFF)
		|=> rd_data == $past(st.irq_enable_group7))
		else $error("group 7 enable read wrong");

	AST_RD_ENABLE8: assert property ( // see RULE13
		rd_strobe && pif_hit(addr, IRQ_ENABLE_GROUP8_OFF)
		|=> rd_data == $past(st.irq_enable_group8) && rd_data[7:6] == 2'b00)
		else $error("group 8 enable read wrong");

	AST_EN7_WRITE: assert property ( // see RULE13
		wr_strobe && pif_hit(addr, IRQ_ENABLE_GROUP7_OFF)
		|=> st.irq_enable_group7 == ($past(wr_data) & GROUP7_IMPL))
		else $error("group 7 enable write not taken");

	AST_EN8_WRITE: assert property ( // see RULE13
		wr_strobe && pif_hit(addr, IRQ_ENABLE_GROUP8_OFF)
		|=> st.irq_enable_group8 == ($past(wr_data) & GROUP8_IMPL))
		else $error("group 8 enable write not taken");

	AST_CTRL_WRITE: assert property ( // see RULE13
		wr_strobe && pif_hit(addr, GLOBAL_IRQ_CONTROL_OFF)
		|=> st.global_irq_enable == $past(wr_data[7])
		&& st.peripheral_irq_enable == $past(wr_data[6]))
		else $error("control write not taken");

	AST_IRQ_DROP: assert property ( // see RULE13
		(st.event_flags_group7 & st.irq_enable_group7) == 8'h00
		&& (st.event_flags_group8 & st.irq_enable_group8) == 8'h00 |-> !irq)
		else $error("irq raised with no enabled flag");

	AST_RESET_REGS: assert property ( // see RULE12
		$past(rst) |-> rd_data == 8'h00 && !irq
		&& st.irq_enable_group7 == 8'h00 && st.irq_enable_group8 == 8'h00)
		else $error("registers not zero after reset");

endmodule : pif_flag_bank
`default_nettype wire

// >>> include/pif_pkg.sv
`default_nettype none
package pif_pkg;
	// Register offsets
	localparam logic [3:0] GLOBAL_IRQ_CONTROL_OFF = 4'h0;
	localparam logic [3:0] IRQ_ENABLE_GROUP7_OFF = 4'h1;
	localparam logic [3:0] IRQ_ENABLE_GROUP8_OFF = 4'h2;
	localparam logic [3:0] EVENT_FLAGS_GROUP7_OFF = 4'h3;
	localparam logic [3:0] EVENT_FLAGS_GROUP8_OFF = 4'h4;
	// Reset values
	localparam logic [7:0] GLOBAL_IRQ_CONTROL_RST = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
	localparam logic [7:0] EVENT_FLAGS_RST = 8'h00;
	// Implemented bit masks
	localparam logic [7:0] GROUP7_IMPL = 8'hf7;
	localparam logic [7:0] GROUP8_IMPL = 8'h3f;
	localparam logic [7:0] CONTROL_IMPL = 8'hc0;
	// Control bit positions
	localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
	localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
	// Group 7 flag positions
	localparam int MEMSCAN_DONE_FLAG_BIT = 7;
	localparam int CHECKSUM_DONE_FLAG_BIT = 6;
	localparam int NVMEM_DONE_FLAG_BIT = 5;
	localparam int OSC_ROLLOVER_FLAG_BIT = 4;
	localparam int WAVEGEN1_SHUTDOWN_FLAG_BIT = 0;
	localparam int WAVEGEN_COUNT = 3;
	// Group 8 flag positions
	localparam int MEASURE1_OVERFLOW_FLAG_BIT = 0;
	localparam int MEASURE1_PERIOD_FLAG_BIT = 1;
	localparam int MEASURE1_WIDTH_FLAG_BIT = 2;
	localparam int MEASURE2_OVERFLOW_FLAG_BIT = 3;
	localparam int MEASURE2_PERIOD_FLAG_BIT = 4;
	localparam int MEASURE2_WIDTH_FLAG_BIT = 5;
	// Read data latency in cycles
	localparam int READ_LATENCY = 1;

	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_irq_enable;
		logic [7:0] irq_enable_group7;
		logic [7:0] irq_enable_group8;
		logic [7:0] event_flags_group7;
		logic [7:0] event_flags_group8;
		logic memscan_go_prev;
		logic checksum_busy_prev;
		logic [2:0] wavegen_shutdown_prev;
		logic [7:0] rd_data;
	} pif_state_t;
endpackage : pif_pkg
`default_nettype wire

// >>> sim/pif_event_model.sv
`default_nettype none
// Peripherals: req bit i raises the event for flag bit i ({group8, group7})
module pif_event_model (
	input wire logic mclk,
	input wire logic [15:0] req,
	output logic memscan_go_bit = 1'b1,
	output logic checksum_busy = 1'b1,
	output logic nvmem_op_done = 1'b0,
	output logic osc_rollover = 1'b0,
	output logic [2:0] wavegen_shutdown = 3'h0,
	output logic [2:0] measure1_ev = 3'h0,
	output logic [2:0] measure2_ev = 3'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Scanner and checksum sit busy; a one-cycle drop is the done event
	always @(posedge mclk) begin
		memscan_go_bit <= ~req[7];
		checksum_busy <= ~req[6];
		nvmem_op_done <= req[5];
		osc_rollover <= req[4];
		wavegen_shutdown <= req[2:0];
		measure1_ev <= req[10:8];
		measure2_ev <= req[13:11];
	end
endmodule : pif_event_model
`default_nettype wire

// >>> sim/peripheral_irq_flag_bank_tb.sv
`default_nettype none
module peripheral_irq_flag_bank_tb
	import pif_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wr_data = 8'h00;
	logic wr_strobe = 1'b0;
	logic rd_strobe = 1'b0;
	logic [15:0] req = 16'h0000;
	logic [7:0] rd_data;
	logic irq, go, busy, nvm, osc;
	logic [2:0] wg, m1, m2;
	logic [31:0] seed = 32'h80a1dde4;
	logic [31:0] r;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	int regs [5] = '{default: 0};
	int pend = 0;

	always #5 mclk = ~mclk;

	pif_event_model periph (.mclk(mclk), .req(req), .memscan_go_bit(go), .checksum_busy(busy),
		.nvmem_op_done(nvm), .osc_rollover(osc), .wavegen_shutdown(wg),
		.measure1_ev(m1), .measure2_ev(m2));

	pif_flag_bank uut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
		.memscan_go_bit(go), .checksum_busy(busy), .nvmem_op_done(nvm), .osc_rollover(osc),
		.wavegen_shutdown(wg), .measure1_overflow(m1[0]), .measure1_period_done(m1[1]),
		.measure1_width_done(m1[2]), .measure2_overflow(m2[0]), .measure2_period_done(m2[1]),
		.measure2_width_done(m2[2]), .irq(irq));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic int imask(logic [3:0] a);
		case (a)
			GLOBAL_IRQ_CONTROL_OFF: return int'(CONTROL_IMPL);
			IRQ_ENABLE_GROUP7_OFF, EVENT_FLAGS_GROUP7_OFF: return int'(GROUP7_IMPL);
			IRQ_ENABLE_GROUP8_OFF, EVENT_FLAGS_GROUP8_OFF: return int'(GROUP8_IMPL);
			default: return 0;
		endcase
	endfunction : imask

	function automatic logic exp_irq();
		return regs[0][GLOBAL_IRQ_ENABLE_BIT] && regs[0][PERIPHERAL_IRQ_ENABLE_BIT]
			&& ((regs[3] & regs[1]) != 0 || (regs[4] & regs[2]) != 0);
	endfunction : exp_irq

	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk

	// Events seen by the bank land after any write at the same edge
	task automatic land();
		regs[3] |= pend & int'(GROUP7_IMPL);
		regs[4] |= (pend >> 8) & int'(GROUP8_IMPL);
		pend = 0;
	endtask : land

	task automatic fire(logic [15:0] v);
		@(posedge mclk);
		req <= v;
		pend = int'(v);
	endtask : fire

	task automatic bus_write(logic [3:0] a, logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_strobe <= 1'b1;
		req <= 16'h0000;
		if (a < 4'h5) regs[a] = int'(d) & imask(a);
		land();
		@(posedge mclk);
		wr_strobe <= 1'b0;
	endtask : bus_write

	task automatic bus_read(logic [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd_strobe <= 1'b1;
		req <= 16'h0000;
		@(posedge mclk);
		rd_strobe <= 1'b0;
		#1;
		chk("read data", rd_data, 8'(a < 4'h5 ? regs[a] : 0));
		land();
		chk("irq", {7'h0, irq}, {7'h0, exp_irq()});
	endtask : bus_read

	task automatic do_reset();
		rst <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		regs = '{default: 0};
		pend = 0;
	endtask : do_reset

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 10000) begin
			mismatches++;
			finish_test();
		end
	end

	initial begin
		do_reset();
		for (int a = 0; a < 16; a++) bus_read(4'(a));
		$display("test reset_values end");
		for (int i = 0; i < 16; i++) begin
			fire(16'(1 << i));
			bus_read(EVENT_FLAGS_GROUP7_OFF);
			bus_read(EVENT_FLAGS_GROUP8_OFF);
			bus_write(EVENT_FLAGS_GROUP7_OFF, 8'h00);
			bus_write(EVENT_FLAGS_GROUP8_OFF, 8'h00);
		end
		$display("test single_sources end");
		for (int a = 3; a < 5; a++) begin
			fire(16'hffff);
			bus_write(4'(a), 8'h00);
			bus_read(4'(a));
		end
		$display("test set_beats_clear end");
		for (int a = 0; a < 16; a++) begin
			bus_write(4'(a), 8'hff);
			bus_read(4'(a));
		end
		$display("test write_all end");
		bus_write(EVENT_FLAGS_GROUP7_OFF, 8'h00);
		bus_write(EVENT_FLAGS_GROUP8_OFF, 8'h00);
		for (int c = 0; c < 4; c++) begin
			bus_write(GLOBAL_IRQ_CONTROL_OFF, 8'(c << 6));
			fire(16'(1 << (c + 9)));
			bus_read(EVENT_FLAGS_GROUP8_OFF);
			bus_write(EVENT_FLAGS_GROUP8_OFF, 8'h00);
			bus_read(GLOBAL_IRQ_CONTROL_OFF);
		end
		$display("test irq_gating end");
		for (int n = 0; n < 400; n++) begin
			r = xs();
			if (r[0]) fire(r[31:16]);
			if (r[1]) bus_write({1'b0, r[4:2]}, r[15:8]);
			else bus_read({1'b0, r[4:2]});
		end
		$display("test random end");
		do_reset();
		for (int a = 0; a < 5; a++) bus_read(4'(a));
		$display("test second_reset end");
		finish_test();
	end
endmodule : peripheral_irq_flag_bank_tb
`default_nettype wire
